//--- logic/kme_pkg.sv
package kme_pkg;
	localparam int DRIVE_N = 11;
	localparam int SENSE_N = 8;
	localparam int CODE_W = 8;
	localparam int DEB_W = 16;
	localparam logic [15:0] DEB_CYCLES = 16'h0400;
	localparam logic [3:0] ASCII_DRIVES = 4'h7;
	localparam logic [7:0] HEX_BASE = 8'h80;
	localparam logic [3:0] CS_ALL = 4'hf;
	localparam logic [7:0] NO_CODE = 8'hff;

	typedef enum logic [3:0] {
		KME_SCAN = 4'h1,
		KME_DEB_DOWN = 4'h2,
		KME_HOLD = 4'h4,
		KME_DEB_UP = 4'h8
	} kme_state_e;

	typedef struct packed {
		logic ctrl;
		logic shift;
		logic alpha;
	} kme_mod_s;
endpackage : kme_pkg

//--- logic/kme_encoder.sv
// Summary of operation
// - eleven drive outputs and eight sense inputs form the switch matrix.
// - sense lines read high only when closed onto the driven line.
// - all chip selects enable the code outputs and qualify the ready clear.
// - code outputs drive the key code when selected, else released.
// - ready flag goes low after a debounced key closure.
// - ready flag returns high on a timing pulse during a selected read.
// - the timing pulse steps the scan and the ready flag; debounce and held flag run on the core clock.
// - held flag goes low while a read key stays closed.
// - a release is valid only after the debounce delay.
// - shift and control are latched after debounce and alter decoding.
// - modifiers alone produce no code and no ready flag.
// - alpha lock is used live, not latched.
// - control overrides shift and alpha; shift applies only without control.
// - drives one to seven give listed ascii codes; unlisted give nothing.
// - drives eight to eleven give hex base plus eight per drive plus sense.
// - up to 53 ascii keys and 32 hex keys, 160 codes total.
// - n-key lockout suppresses spurious codes from multiple keys.
// - drive lines go high strictly one at a time.
// - scan stops in the core clock cycle a valid keydown is seen, without waiting for a pulse.
// - ready flag stays high until release and a new keydown.
// - only the first key in scan order is recognised until released and read.
`timescale 1ns/1ps
`default_nettype none
module kme_encoder #(
	parameter logic [15:0] DEB_CYCLES = kme_pkg::DEB_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic host_timing_pulse_in,
	input wire logic [7:0] matrix_sense_lines_in,
	input wire logic [3:0] chip_select_inputs_in,
	input wire logic shift_in,
	input wire logic control_in,
	input wire logic alpha_lock_in,
	output logic [10:0] matrix_drive_lines_out,
	output logic [7:0] key_code_out,
	output logic [7:0] key_code_oe_n_out,
	output logic key_ready_flag_n_out,
	output logic key_held_flag_n_out
);
	// ----------------------------------------
	// reset and timing pulse edge
	// ----------------------------------------
	logic rst_s1_ff, rst_s2_ff;
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	wire rstn = rst_s2_ff;

	logic tp_d_ff;
	wire tp_rise = host_timing_pulse_in & ~tp_d_ff;
	wire tp_fall = ~host_timing_pulse_in & tp_d_ff;

	// ----------------------------------------
	// ascii lookup: drive 0..6, sense 0..7, mapping
	// ----------------------------------------
	function automatic logic [7:0] kme_ascii(input logic [3:0] d, input logic [2:0] s,
		input logic [1:0] m);
		logic [7:0] c;
		c = kme_pkg::NO_CODE;
		case (d)
			4'h0: c = (m == 2'h1) ? (8'h20 + 8'(s)) : (8'h30 + 8'(s));
			4'h1: c = (s < 3'h2) ? ((m == 2'h1) ? (8'h28 + 8'(s)) : (8'h38 + 8'(s)))
				: ((m == 2'h1) ? (8'h38 + 8'(s)) : (8'h28 + 8'(s)));
			4'h2, 4'h3, 4'h4, 4'h5: c = 8'h40 + {2'h0, d[2:0] - 3'h2, s} +
				((m == 2'h0) ? 8'h20 : 8'h00);
			default: c = kme_pkg::NO_CODE;
		endcase
		if (d == 4'h6) begin
			case (s)
				3'h0: c = kme_pkg::NO_CODE;
				3'h1: c = 8'h20;
				3'h2: c = 8'h0a;
				3'h3: c = 8'h1b;
				3'h5: c = 8'h0d;
				3'h7: c = 8'h7f;
				default: c = kme_pkg::NO_CODE;
			endcase
		end else if (m == 2'h3 && d > 4'h1) begin
			c = c & 8'h1f;
		end
		if (d == 4'h5 && m == 2'h0 && s > 3'h2) c = 8'h78 + 8'(s);
		return c;
	endfunction : kme_ascii

	// ----------------------------------------
	// scan, debounce and flag machine
	// ----------------------------------------
	kme_pkg::kme_state_e state_ff, nxt_state;
	logic [3:0] drv_ff, nxt_drv;
	logic [2:0] sns_ff, nxt_sns;
	logic [15:0] deb_ff, nxt_deb;
	logic ready_n_ff, nxt_ready_n;
	logic held_n_ff, nxt_held_n;
	logic read_done_ff, nxt_read_done;
	logic shift_l_ff, ctrl_l_ff;
	logic [7:0] code_ff, nxt_code;

	wire sel = (chip_select_inputs_in == kme_pkg::CS_ALL);
	// the registered drive lags the counter by a cycle after a wrap; only trust the sense line
	// once the pin really drives the counted line, so a key on the previous drive is not misread
	wire key_hit = matrix_sense_lines_in[sns_ff] & matrix_drive_lines_out[drv_ff];
	wire [1:0] map = ctrl_l_ff ? 2'h3 : (shift_l_ff ? 2'h1 : (alpha_lock_in ? 2'h2 : 2'h0));
	wire [7:0] hex_code = kme_pkg::HEX_BASE + {1'b0, 4'(drv_ff - kme_pkg::ASCII_DRIVES), sns_ff};
	wire [7:0] cur_code = (drv_ff >= kme_pkg::ASCII_DRIVES) ? hex_code : kme_ascii(drv_ff, sns_ff, map);
	wire deb_done = (deb_ff >= DEB_CYCLES);

	always_comb begin
		nxt_state = state_ff;
		nxt_drv = drv_ff;
		nxt_sns = sns_ff;
		nxt_deb = deb_ff;
		nxt_ready_n = ready_n_ff;
		nxt_held_n = held_n_ff;
		nxt_read_done = read_done_ff;
		nxt_code = code_ff;
		if (tp_rise && sel && !ready_n_ff) begin
			nxt_ready_n = 1'b1;
			nxt_read_done = 1'b1;
		end
		case (state_ff)
			kme_pkg::KME_SCAN: begin
				nxt_deb = '0;
				if (key_hit && cur_code != kme_pkg::NO_CODE) begin
					nxt_state = kme_pkg::KME_DEB_DOWN;
					nxt_code = cur_code;
				end else if (tp_fall) begin
					nxt_sns = sns_ff + 3'h1;
					if (sns_ff == 3'h7) nxt_drv = (drv_ff == 4'ha) ? 4'h0 : drv_ff + 4'h1;
				end
			end
			kme_pkg::KME_DEB_DOWN: begin
				if (!key_hit) nxt_state = kme_pkg::KME_SCAN;
				else if (!deb_done) nxt_deb = deb_ff + 16'h1;
				else if (tp_rise) begin
					nxt_state = kme_pkg::KME_HOLD;
					nxt_ready_n = 1'b0;
					nxt_read_done = 1'b0;
					nxt_deb = '0;
				end
			end
			kme_pkg::KME_HOLD: begin
				if (read_done_ff && ready_n_ff && key_hit) nxt_held_n = 1'b0;
				if (!key_hit) nxt_state = kme_pkg::KME_DEB_UP;
			end
			kme_pkg::KME_DEB_UP: begin
				if (key_hit) begin
					nxt_state = kme_pkg::KME_HOLD;
					nxt_deb = '0;
				end else if (!deb_done) nxt_deb = deb_ff + 16'h1;
				else begin
					nxt_held_n = 1'b1;
					if (read_done_ff && ready_n_ff) nxt_state = kme_pkg::KME_SCAN;
				end
			end
			default: nxt_state = kme_pkg::KME_SCAN;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rstn) begin
		if (!rstn) begin
			tp_d_ff <= 1'b0;
			state_ff <= kme_pkg::KME_SCAN;
			drv_ff <= '0;
			sns_ff <= '0;
			deb_ff <= '0;
			ready_n_ff <= 1'b1;
			held_n_ff <= 1'b1;
			read_done_ff <= 1'b1;
			code_ff <= '0;
		end else begin
			tp_d_ff <= host_timing_pulse_in;
			state_ff <= nxt_state;
			drv_ff <= nxt_drv;
			sns_ff <= nxt_sns;
			deb_ff <= nxt_deb;
			ready_n_ff <= nxt_ready_n;
			held_n_ff <= nxt_held_n;
			read_done_ff <= nxt_read_done;
			code_ff <= nxt_code;
		end
	end

	// ----------------------------------------
	// modifier latch and outputs
	// ----------------------------------------
	logic [15:0] mod_cnt_ff;
	wire mod_raw = shift_in | control_in;
	always_ff @(posedge core_clk_in or negedge rstn) begin
		if (!rstn) begin
			mod_cnt_ff <= '0;
			shift_l_ff <= 1'b0;
			ctrl_l_ff <= 1'b0;
		end else begin
			mod_cnt_ff <= (mod_raw && ({shift_l_ff, ctrl_l_ff} != {shift_in, control_in}) &&
				mod_cnt_ff < DEB_CYCLES) ? mod_cnt_ff + 16'h1 : '0;
			if (!mod_raw || mod_cnt_ff >= DEB_CYCLES) begin
				shift_l_ff <= shift_in;
				ctrl_l_ff <= control_in;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn) begin
		if (!rstn) begin
			matrix_drive_lines_out <= '0;
			key_code_out <= '0;
			key_code_oe_n_out <= '1;
			key_ready_flag_n_out <= 1'b1;
			key_held_flag_n_out <= 1'b1;
		end else begin
			matrix_drive_lines_out <= 11'h1 << drv_ff;
			key_code_out <= code_ff;
			key_code_oe_n_out <= {8{~sel}};
			key_ready_flag_n_out <= ready_n_ff;
			key_held_flag_n_out <= held_n_ff;
		end
	end
endmodule : kme_encoder
`default_nettype wire

//--- verification/kme_encoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module kme_encoder_mon (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic host_timing_pulse_in,
	input wire logic [7:0] matrix_sense_lines_in,
	input wire logic [3:0] chip_select_inputs_in,
	input wire logic [10:0] matrix_drive_lines_out,
	input wire logic [7:0] key_code_out,
	input wire logic [7:0] key_code_oe_n_out,
	input wire logic key_ready_flag_n_out,
	input wire logic key_held_flag_n_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	chk_drive_one_hot: assert property ($onehot0(matrix_drive_lines_out))
		else $error("drive lines not one-hot");
	chk_bus_on_select: assert property (chip_select_inputs_in == 4'hf |=> key_code_oe_n_out == 8'h00)
		else $error("bus not driven while selected");
	chk_bus_off_idle: assert property (chip_select_inputs_in != 4'hf |=> key_code_oe_n_out == 8'hff)
		else $error("bus driven while not selected");
	chk_ready_read_clear: assert property ($rose(host_timing_pulse_in) && chip_select_inputs_in == 4'hf
		&& !key_ready_flag_n_out |-> ##[1:6] key_ready_flag_n_out)
		else $error("ready not cleared by read");
	chk_scan_frozen: assert property (!key_ready_flag_n_out |-> $stable(matrix_drive_lines_out))
		else $error("scan moved while ready");
	chk_code_frozen: assert property (!key_ready_flag_n_out |-> $stable(key_code_out))
		else $error("code moved while ready");
	chk_held_blocks_ready: assert property (!key_held_flag_n_out |-> key_ready_flag_n_out)
		else $error("ready low while key held");
	chk_ready_needs_key: assert property ($fell(key_ready_flag_n_out) |-> |matrix_sense_lines_in)
		else $error("ready without closed key");
	chk_held_after_read: assert property ($fell(key_held_flag_n_out) |->
		|matrix_sense_lines_in && key_ready_flag_n_out)
		else $error("held without read closed key");
endmodule : kme_encoder_mon
bind kme_encoder kme_encoder_mon u_kme_encoder_mon (.core_clk_in, .resetn_in,
	.host_timing_pulse_in, .matrix_sense_lines_in, .chip_select_inputs_in, .matrix_drive_lines_out,
	.key_code_out, .key_code_oe_n_out, .key_ready_flag_n_out, .key_held_flag_n_out);
`default_nettype wire

//--- verification/kme_keyboard_model.sv
`timescale 1ns/1ps
`default_nettype none
module kme_keyboard_model (
	input wire logic [10:0] drive_in,
	input wire logic key_on_in,
	input wire logic [3:0] key_drive_in,
	input wire logic [2:0] key_sense_in,
	output logic [7:0] sense_out
);
	// open sense lines sit at the pull-down level
	assign sense_out = (key_on_in && drive_in[key_drive_in]) ? 8'h01 << key_sense_in : 8'h00;
endmodule : kme_keyboard_model
`default_nettype wire

//--- verification/kme_encoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module kme_encoder_tb_top;
	logic clk, kon = 1'b0, rstn = 1'b0, tp = 1'b0, sh = 1'b0, ct = 1'b0, al = 1'b0;
	logic [3:0] cs = 4'h0, kd = 4'h0;
	logic [2:0] ks = 3'h0, tcnt = 3'h0;
	logic [10:0] drv;
	logic [7:0] sense, code, oe;
	logic rdy, held;
	int failures = 0, checks = 0;
	kme_encoder #(.DEB_CYCLES(16'h0004)) u_kme_encoder (.core_clk_in(clk), .resetn_in(rstn),
		.host_timing_pulse_in(tp), .matrix_sense_lines_in(sense), .chip_select_inputs_in(cs),
		.shift_in(sh), .control_in(ct), .alpha_lock_in(al), .matrix_drive_lines_out(drv),
		.key_code_out(code), .key_code_oe_n_out(oe), .key_ready_flag_n_out(rdy),
		.key_held_flag_n_out(held));
	kme_keyboard_model u_kme_keyboard_model (.drive_in(drv), .key_on_in(kon),
		.key_drive_in(kd), .key_sense_in(ks), .sense_out(sense));
	// ---
	// clock, host pulse and compare
	// ---
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		tcnt <= tcnt + 3'h1;
		tp <= tcnt[2];
	end
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic press(input logic [3:0] d, input logic [2:0] s, input kme_pkg::kme_mod_s m,
		input logic [7:0] e);
		{ct, sh, al} <= m;
		repeat (40) @(posedge clk);
		{kon, kd, ks} <= {1'b1, d, s};
		repeat (3000) if (rdy !== 1'b0) @(posedge clk);
		cmp("key code", e, code);
		cs <= 4'hf;
		repeat (2) @(posedge clk);
		cmp("bus enable", 8'h00, oe);
		repeat (60) if (rdy !== 1'b1) @(posedge clk);
		cmp("ready clear", 8'h01, {7'h0, rdy});
		cs <= 4'h0;
		repeat (20) @(posedge clk);
		cmp("key held", 8'h00, {7'h0, held});
		{kon, ct, sh, al} <= 4'h0;
		repeat (200) if (held !== 1'b1) @(posedge clk);
		cmp("held release", 8'h01, {7'h0, held});
	endtask : press
	// ---
	// scenarios
	// ---
	task automatic test_mod_alone;
		{ct, sh} <= 2'h3;
		repeat (1500) @(posedge clk);
		cmp("ready idle", 8'h01, {7'h0, rdy});
		{ct, sh} <= 2'h0;
		$display("modifier test done");
	endtask : test_mod_alone
	task automatic test_ascii;
		logic [7:0] e [6] = '{8'h61, 8'h41, 8'h41, 8'h01, 8'h01, 8'h01};
		logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
		for (int i = 0; i < 6; i++) begin
			press(4'h2, 3'h1, m[i], e[i]);
		end
		press(4'h6, 3'h2, 3'h7, 8'h0a);
		$display("ascii test done");
	endtask : test_ascii
	task automatic test_hex;
		press(4'h7, 3'h0, 3'h0, 8'h80);
		press(4'h8, 3'h4, 3'h0, 8'h8c);
		press(4'ha, 3'h7, 3'h0, 8'h9f);
		$display("hex test done");
	endtask : test_hex
	task automatic complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
		test_mod_alone();
		test_ascii();
		test_hex();
		complete_run();
	end
endmodule : kme_encoder_tb_top
`default_nettype wire
